//--- src/gfc_port_cfg.svh
// Constants for the flow control serial ports
// Assumes inclusion by bare name from the package and design modules
//
// Overview of operation
// - Receive marker coincides with field most significant bit
// - Receive outputs change on output clock fall
// - Receive field shifted out most significant first
// - Per-bit gate mask suppresses receive bits
// - Receive serial output low while delineation lost
// - Transmit marker one period, bit 3 follows
// - Transmit marker changes on output clock fall
// - Insert transmit bits into every cell
// - Per-bit enables choose serial or internal value
// - Transmit serial input sampled on clock rise
`ifndef GFC_PORT_CFG_SVH
`define GFC_PORT_CFG_SVH

// ============================================================
// Field layout
`define GFC_FIELD_BITS 4
`define GFC_FIELD_MSB 3

// ============================================================
// Timing
`define GFC_CLK_PERIOD_NS 8
`define GFC_LINK_PERIOD_NS 64
`define GFC_LINK_HALF_CYCLES (`GFC_LINK_PERIOD_NS / (2 * `GFC_CLK_PERIOD_NS))
`define GFC_SYNC_STAGES 2

// ============================================================
// Reset values
`define GFC_RST_LINK_CLK 1'b0
`define GFC_RST_MARKER 1'b0
`define GFC_RST_SERIAL 1'b0
`define GFC_RST_FIELD 4'h0

`endif

//--- src/gfc_port_pkg.sv
// Types shared by the flow control serial port modules
// Assumes nothing beyond the constants header
`include "gfc_port_cfg.svh"
package gfc_port_pkg;

    typedef logic [`GFC_FIELD_BITS-1:0] gfc_field_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_MARK,
        TX_BITS
    } tx_state_t;

endpackage

//--- src/link_tick_if.sv
// Output clock level and its edge enables
// Assumes one generator and one consumer on the same clock
interface link_tick_if;
    logic lvl;
    logic rise;
    logic fall;

    modport gen (output lvl, output rise, output fall);
    modport use_side (input lvl, input rise, input fall);
endinterface

//--- src/link_clock_gen.sv
// Divider making one output clock with rise and fall enables
// Assumes clk runs free; edges are enables, not clocks
`include "gfc_port_cfg.svh"
module link_clock_gen #(
    parameter int HALF_CYCLES = `GFC_LINK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Tick carrier
    link_tick_if.gen tick
);

    localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

    logic [CW-1:0] cnt_q;
    logic lvl_q;
    logic wrap;

    assign wrap = (cnt_q == CW'(HALF_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
        end
        else if (wrap)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_q <= `GFC_RST_LINK_CLK;
        end
        else if (wrap)
        begin
            lvl_q <= ~lvl_q;
        end
    end

    // Edge enables fire on the edge where the level flips
    assign tick.lvl = lvl_q;
    assign tick.rise = wrap & ~lvl_q;
    assign tick.fall = wrap & lvl_q;

endmodule

//--- src/gfc_serial_ports.sv
// Receive and transmit flow control serial ports
// Assumes cell logic on clk; serial pins are outside this domain
// Output clocks run free and are never gapped
`include "gfc_port_cfg.svh"
module gfc_serial_ports #(
    parameter int HALF_CYCLES = `GFC_LINK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Receive cell processor side
    input wire logic rx_cell_valid,
    input wire logic [`GFC_FIELD_BITS-1:0] rx_gfc_field,
    input wire logic out_of_cell_delineation,
    input wire logic [`GFC_FIELD_BITS-1:0] rx_gfc_gate,
    // Receive serial pins
    output logic rx_output_clock,
    output logic rx_cell_marker,
    output logic rx_flow_ctrl_serial,
    // Transmit cell processor side
    input wire logic tx_cell_req,
    input wire logic [`GFC_FIELD_BITS-1:0] tx_gfc_insert_en,
    input wire logic [`GFC_FIELD_BITS-1:0] tx_gfc_internal,
    output logic tx_gfc_valid,
    output logic [`GFC_FIELD_BITS-1:0] tx_gfc_field,
    // Transmit serial pins
    output logic tx_output_clock,
    output logic tx_cell_marker,
    input wire logic tx_flow_ctrl_serial
);

    localparam int FB = `GFC_FIELD_BITS;
    localparam int LW = $clog2(FB + 1);
    localparam int SL = `GFC_SYNC_STAGES - 1;

    // ============================================================
    // Decodes used by the receive shifter and by several transmit processes
    function automatic logic rx_pin_bit(input logic b, input logic lost);
        rx_pin_bit = b & ~lost;
    endfunction

    function automatic logic tx_in_state(input gfc_port_pkg::tx_state_t s,
        input gfc_port_pkg::tx_state_t want);
        tx_in_state = (s == want);
    endfunction

    // ============================================================
    // Output clocks
    link_tick_if rx_tick ();
    link_tick_if tx_tick ();

    link_clock_gen #(.HALF_CYCLES(HALF_CYCLES)) u_rx_clk (
        .clk(clk),
        .rst_n(rst_n),
        .tick(rx_tick)
    );

    link_clock_gen #(.HALF_CYCLES(HALF_CYCLES)) u_tx_clk (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tx_tick)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_output_clock <= `GFC_RST_LINK_CLK;
            tx_output_clock <= `GFC_RST_LINK_CLK;
        end
        else
        begin
            // Pin takes the level the divider moves to, so pin edges land
            // on the same clk edge as the data launched by the enables
            rx_output_clock <= rx_tick.lvl ^ (rx_tick.rise | rx_tick.fall);
            tx_output_clock <= tx_tick.lvl ^ (tx_tick.rise | tx_tick.fall);
        end
    end

    // ============================================================
    // Receive: hold next field until the shifter is free
    logic rx_pend_q;
    gfc_port_pkg::gfc_field_t rx_pend_field_q;
    gfc_port_pkg::gfc_field_t rx_shift_q;
    logic [LW-1:0] rx_left_q;
    logic rx_load;

    // A newer cell replaces a field still waiting; only one is held
    assign rx_load = rx_tick.fall & rx_pend_q & (rx_left_q == '0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_pend_q <= 1'b0;
            rx_pend_field_q <= `GFC_RST_FIELD;
        end
        else if (out_of_cell_delineation)
        begin
            rx_pend_q <= 1'b0;
        end
        else if (rx_cell_valid)
        begin
            rx_pend_q <= 1'b1;
            rx_pend_field_q <= rx_gfc_field & ~rx_gfc_gate;
        end
        else if (rx_load)
        begin
            rx_pend_q <= 1'b0;
        end
    end

    // Field is taken when the cell arrives; the gate mask applies then
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_shift_q <= `GFC_RST_FIELD;
            rx_left_q <= '0;
            rx_flow_ctrl_serial <= `GFC_RST_SERIAL;
        end
        else if (rx_tick.fall)
        begin
            if (rx_load)
            begin
                rx_shift_q <= rx_pend_field_q << 1;
                rx_left_q <= LW'(FB - 1);
                rx_flow_ctrl_serial <= rx_pin_bit(rx_pend_field_q[FB-1],
                    out_of_cell_delineation);
            end
            else if (rx_left_q != '0)
            begin
                rx_shift_q <= rx_shift_q << 1;
                rx_left_q <= rx_left_q - LW'(1);
                rx_flow_ctrl_serial <= rx_pin_bit(rx_shift_q[FB-1],
                    out_of_cell_delineation);
            end
            else
            begin
                rx_flow_ctrl_serial <= 1'b0;
            end
        end
    end

    // ============================================================
    // Receive marker: high for the period that carries the field MSB
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_cell_marker <= `GFC_RST_MARKER;
        end
        else if (rx_tick.fall)
        begin
            rx_cell_marker <= rx_load;
        end
    end

    // ============================================================
    // Transmit: pin synchroniser and delayed rise enable
    logic [`GFC_SYNC_STAGES-1:0] tx_sync_q;
    logic [`GFC_SYNC_STAGES-1:0] tx_rise_dly_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_sync_q <= '0;
            tx_rise_dly_q <= '0;
        end
        else
        begin
            tx_sync_q <= {tx_sync_q[0], tx_flow_ctrl_serial};
            tx_rise_dly_q <= {tx_rise_dly_q[0], tx_tick.rise};
        end
    end

    // ============================================================
    // Transmit: marker, bit capture and field merge
    gfc_port_pkg::tx_state_t tx_state_q;
    logic tx_req_q;
    gfc_port_pkg::gfc_field_t tx_cap_q;
    logic [LW-1:0] tx_got_q;
    logic tx_sample;
    logic tx_done;
    logic tx_launch;
    gfc_port_pkg::gfc_field_t tx_next_field;
    wire [FB-1:0] tx_merge;

    // Pin level at the rise, seen after the synchroniser delay
    assign tx_sample = tx_rise_dly_q[SL] & tx_in_state(tx_state_q, gfc_port_pkg::TX_BITS);
    // Last of the four bits completes the field
    assign tx_done = tx_sample & (tx_got_q == LW'(FB - 1));
    // Marker starts only from idle, at an output clock fall
    assign tx_launch = tx_tick.fall & tx_req_q & tx_in_state(tx_state_q, gfc_port_pkg::TX_IDLE);
    assign tx_next_field = {tx_cap_q[FB-2:0], tx_sync_q[SL]};

    // ============================================================
    // Transmit: per-bit choice between serial and internal value
    for (genvar gi = 0; gi < FB; gi++)
    begin : g_merge
        assign tx_merge[gi] = tx_gfc_insert_en[gi] ? tx_next_field[gi]
            : tx_gfc_internal[gi];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_req_q <= 1'b0;
        end
        else if (tx_cell_req)
        begin
            tx_req_q <= 1'b1;
        end
        else if (tx_launch)
        begin
            tx_req_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state_q <= gfc_port_pkg::TX_IDLE;
        end
        else
        begin
            case (tx_state_q)
                gfc_port_pkg::TX_IDLE:
                begin
                    if (tx_launch)
                    begin
                        tx_state_q <= gfc_port_pkg::TX_MARK;
                    end
                end
                gfc_port_pkg::TX_MARK:
                begin
                    if (tx_tick.fall)
                    begin
                        tx_state_q <= gfc_port_pkg::TX_BITS;
                    end
                end
                gfc_port_pkg::TX_BITS:
                begin
                    if (tx_done)
                    begin
                        tx_state_q <= gfc_port_pkg::TX_IDLE;
                    end
                end
                default:
                begin
                    tx_state_q <= gfc_port_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Transmit marker: the period just ahead of bit 3
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_cell_marker <= `GFC_RST_MARKER;
        end
        else if (tx_tick.fall)
        begin
            tx_cell_marker <= tx_launch;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_cap_q <= `GFC_RST_FIELD;
            tx_got_q <= '0;
        end
        else if (!tx_in_state(tx_state_q, gfc_port_pkg::TX_BITS))
        begin
            tx_got_q <= '0;
        end
        else if (tx_sample)
        begin
            tx_cap_q <= tx_next_field;
            tx_got_q <= tx_got_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_gfc_valid <= 1'b0;
            tx_gfc_field <= `GFC_RST_FIELD;
        end
        else
        begin
            tx_gfc_valid <= tx_done;
            if (tx_done)
            begin
                tx_gfc_field <= tx_merge;
            end
        end
    end

endmodule

//--- dv/gfc_far_end.sv
// Far-end flow control logic: sources transmit bits, collects receive fields
// Assumes the device output clocks and markers as its only timing
module gfc_far_end (
    // Transmit pins
    input wire logic tx_output_clock,
    input wire logic tx_cell_marker,
    output logic tx_flow_ctrl_serial,
    input wire logic [3:0] tx_pat,
    // Receive pins
    input wire logic rx_output_clock,
    input wire logic rx_cell_marker,
    input wire logic rx_flow_ctrl_serial,
    output logic [3:0] rx_got,
    output int rx_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Transmit source
    int tx_k = 0;
    int rx_k = 4;
    logic seen_q = 1'b0;
    logic [3:0] rx_sh = 4'h0;
    initial tx_flow_ctrl_serial = 1'b0;
    initial rx_n = 0;
    initial rx_got = 4'h0;
    // Marker is sampled on the rise, like any device output
    always @(posedge tx_output_clock)
        seen_q = tx_cell_marker;
    always @(negedge tx_output_clock)
    begin
        if (seen_q)
        begin
            tx_flow_ctrl_serial <= tx_pat[3];
            tx_k = 3;
        end
        else if (tx_k > 0)
        begin
            tx_flow_ctrl_serial <= tx_pat[tx_k-1];
            tx_k--;
        end
        else
            tx_flow_ctrl_serial <= ~tx_flow_ctrl_serial;
    end
    // ==========
    // Receive sink
    always @(posedge rx_output_clock)
    begin
        if (rx_cell_marker)
            rx_k = 0;
        if (rx_k < 4)
        begin
            rx_sh = {rx_sh[2:0], rx_flow_ctrl_serial};
            rx_k++;
            if (rx_k == 4)
            begin
                rx_got = rx_sh;
                rx_n++;
            end
        end
    end
endmodule

//--- dv/gfc_serial_ports_monitor.sv
// Pin-level checks of the flow control serial ports
// Assumes binding to gfc_serial_ports with four clk per half period
`include "gfc_port_cfg.svh"
module gfc_serial_ports_monitor #(
    parameter int HALF_CYCLES = `GFC_LINK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Receive side
    input wire logic rx_cell_valid,
    input wire logic [`GFC_FIELD_BITS-1:0] rx_gfc_field,
    input wire logic out_of_cell_delineation,
    input wire logic [`GFC_FIELD_BITS-1:0] rx_gfc_gate,
    input wire logic rx_output_clock,
    input wire logic rx_cell_marker,
    input wire logic rx_flow_ctrl_serial,
    // Transmit side
    input wire logic tx_gfc_valid,
    input wire logic [`GFC_FIELD_BITS-1:0] tx_gfc_field,
    input wire logic tx_output_clock,
    input wire logic tx_cell_marker
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Expected receive field
    logic [3:0] exp_q;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            exp_q <= 4'h0;
        else if (rx_cell_valid && !out_of_cell_delineation)
            exp_q <= rx_gfc_field & ~rx_gfc_gate;
    sequence s_rx_field;
        rx_flow_ctrl_serial == exp_q[3] ##8 rx_flow_ctrl_serial == exp_q[2]
        ##8 rx_flow_ctrl_serial == exp_q[1] ##8 rx_flow_ctrl_serial == exp_q[0];
    endsequence
    sequence s_period(m);
        m[*8] ##1 !m;
    endsequence
    // ==========
    // Checks
    a_rx_field_order:
        assert property ($rose(rx_cell_marker) |-> s_rx_field) else $error("rx field bad");
    a_rx_mark_fall:
        assert property ($changed(rx_cell_marker) |-> $fell(rx_output_clock))
        else $error("rx marker off fall");
    a_rx_data_fall:
        assert property ($changed(rx_flow_ctrl_serial) |-> $fell(rx_output_clock))
        else $error("rx serial off fall");
    a_tx_mark_fall:
        assert property ($changed(tx_cell_marker) |-> $fell(tx_output_clock))
        else $error("tx marker off fall");
    a_rx_mark_len:
        assert property ($rose(rx_cell_marker) |-> s_period(rx_cell_marker))
        else $error("rx marker length");
    a_tx_mark_len:
        assert property ($rose(tx_cell_marker) |-> s_period(tx_cell_marker))
        else $error("tx marker length");
    a_ocd_serial_low:
        assert property (out_of_cell_delineation[*8] ##1 out_of_cell_delineation
            |-> !rx_flow_ctrl_serial) else $error("rx serial not low");
    a_tx_field_time:
        assert property ($fell(tx_cell_marker) |-> ##[30:32] tx_gfc_valid)
        else $error("tx field late");
    a_tx_field_hold:
        assert property ($changed(tx_gfc_field) |-> tx_gfc_valid) else $error("tx field moved");
endmodule
bind gfc_serial_ports gfc_serial_ports_monitor #(.HALF_CYCLES(HALF_CYCLES)) mon_u (
    .clk(clk),
    .rst_n(rst_n),
    .rx_cell_valid(rx_cell_valid),
    .rx_gfc_field(rx_gfc_field),
    .out_of_cell_delineation(out_of_cell_delineation),
    .rx_gfc_gate(rx_gfc_gate),
    .rx_output_clock(rx_output_clock),
    .rx_cell_marker(rx_cell_marker),
    .rx_flow_ctrl_serial(rx_flow_ctrl_serial),
    .tx_gfc_valid(tx_gfc_valid),
    .tx_gfc_field(tx_gfc_field),
    .tx_output_clock(tx_output_clock),
    .tx_cell_marker(tx_cell_marker)
);

//--- dv/tb.sv
// Self-checking bench for the flow control serial ports
// Assumes far-end model and checker compiled before it
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_cell_valid = 1'b0;
    logic out_of_cell_delineation = 1'b0;
    logic tx_cell_req = 1'b0;
    logic [3:0] rx_gfc_field = 4'h0;
    logic [3:0] rx_gfc_gate = 4'h0;
    logic [3:0] tx_gfc_insert_en = 4'h0;
    logic [3:0] tx_gfc_internal = 4'h0;
    logic [3:0] tx_pat = 4'h0;
    logic rx_output_clock, rx_cell_marker, rx_flow_ctrl_serial;
    logic tx_gfc_valid, tx_output_clock, tx_cell_marker, tx_flow_ctrl_serial;
    logic [3:0] tx_gfc_field, rx_got;
    int rx_n;
    int err_total = 0;
    int samples_checked = 0;
    gfc_serial_ports #(.HALF_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n),
        .rx_cell_valid(rx_cell_valid), .rx_gfc_field(rx_gfc_field),
        .out_of_cell_delineation(out_of_cell_delineation), .rx_gfc_gate(rx_gfc_gate),
        .rx_output_clock(rx_output_clock), .rx_cell_marker(rx_cell_marker),
        .rx_flow_ctrl_serial(rx_flow_ctrl_serial), .tx_cell_req(tx_cell_req),
        .tx_gfc_insert_en(tx_gfc_insert_en), .tx_gfc_internal(tx_gfc_internal),
        .tx_gfc_valid(tx_gfc_valid), .tx_gfc_field(tx_gfc_field),
        .tx_output_clock(tx_output_clock), .tx_cell_marker(tx_cell_marker),
        .tx_flow_ctrl_serial(tx_flow_ctrl_serial));
    gfc_far_end far_u (.tx_output_clock(tx_output_clock), .tx_cell_marker(tx_cell_marker),
        .tx_flow_ctrl_serial(tx_flow_ctrl_serial), .tx_pat(tx_pat),
        .rx_output_clock(rx_output_clock), .rx_cell_marker(rx_cell_marker),
        .rx_flow_ctrl_serial(rx_flow_ctrl_serial), .rx_got(rx_got), .rx_n(rx_n));
    initial forever #4 clk = ~clk;
    // ==========
    // Shared tasks
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string nm, logic [3:0] e, logic [3:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_on(bit tx, int n0);
        for (int i = 0; i < 400; i++)
        begin
            @(posedge clk);
            if (tx ? tx_gfc_valid === 1'b1 : rx_n != n0)
                return;
        end
        err_total++;
        $display("ERROR wait expected 1 seen 0");
        test_done();
    endtask
    // ==========
    // Scenarios
    task automatic t_rx(logic [3:0] f, logic [3:0] g);
        int n0;
        n0 = rx_n;
        rx_gfc_field <= f;
        rx_gfc_gate <= g;
        rx_cell_valid <= 1'b1;
        @(posedge clk);
        rx_cell_valid <= 1'b0;
        wait_on(0, n0);
        check("rx_field", f & ~g, rx_got);
        $display("t_rx done");
    endtask
    task automatic t_ocd();
        logic [1:0] seen;
        seen = 2'b00;
        repeat (16) @(posedge clk);
        out_of_cell_delineation <= 1'b1;
        @(posedge clk);
        rx_gfc_field <= 4'hf;
        rx_cell_valid <= 1'b1;
        @(posedge clk);
        rx_cell_valid <= 1'b0;
        repeat (48)
        begin
            @(posedge clk);
            seen = seen | {rx_cell_marker, rx_flow_ctrl_serial};
        end
        out_of_cell_delineation <= 1'b0;
        check("rx_ocd", 4'h0, {2'b00, seen});
        $display("t_ocd done");
    endtask
    task automatic t_tx(logic [3:0] f, logic [3:0] en, logic [3:0] iv);
        tx_pat <= f;
        tx_gfc_insert_en <= en;
        tx_gfc_internal <= iv;
        tx_cell_req <= 1'b1;
        @(posedge clk);
        tx_cell_req <= 1'b0;
        wait_on(1, 0);
        check("tx_field", (f & en) | (iv & ~en), tx_gfc_field);
        $display("t_tx done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_rx(4'ha, 4'h0);
        t_rx(4'h9, 4'h6);
        t_rx(4'hf, 4'h5);
        t_ocd();
        t_tx(4'hc, 4'hf, 4'h3);
        t_tx(4'hc, 4'h0, 4'h5);
        t_tx(4'h6, 4'ha, 4'h9);
        test_done();
    end
endmodule
